/* fr_regs.svh */
`ifndef FR_REGS_SVH
`define FR_REGS_SVH

// Opcodes
`define FR_OP_SET_WEL 8'h06
`define FR_OP_CLR_WEL 8'h04
`define FR_OP_SR_RD 8'h05
`define FR_OP_SR_WR 8'h01
`define FR_OP_RD 8'h03
`define FR_OP_FRD 8'h0B
`define FR_OP_WR 8'h02
`define FR_OP_SLEEP 8'hB9
`define FR_OP_ID 8'h9F

// Address layout
`define FR_ADDR_W 18
`define FR_ADDR_LAST 2'h2

// Bit framing
`define FR_BIT_LAST 3'h7
`define FR_BIT_FIRST 3'h0

// Status register layout
`define FR_SR_WPEN 7
`define FR_SR_BP1 3
`define FR_SR_BP0 2
`define FR_SR_WEL 1
`define FR_SR_FIXED 8'h40
`define FR_SR_BP_RST 2'h0
`define FR_SR_WPEN_RST 1'h0

// Protected block codes and top address bits
`define FR_BP_NONE 2'h0
`define FR_BP_QUARTER 2'h1
`define FR_BP_HALF 2'h2
`define FR_TOP_QUARTER 2'h3

// Identification length in bytes
`define FR_ID_LEN 9

`endif

/* fr_pkg.sv */
`include "fr_regs.svh"

package fr_pkg;
   timeunit 1ns;
   timeprecision 100ps;

   typedef enum logic [3:0] {
      FR_CMD_NONE,
      FR_CMD_SET_WEL,
      FR_CMD_CLR_WEL,
      FR_CMD_SR_RD,
      FR_CMD_SR_WR,
      FR_CMD_RD,
      FR_CMD_FRD,
      FR_CMD_WR,
      FR_CMD_SLEEP,
      FR_CMD_ID,
      FR_CMD_BAD
   } fr_cmd_t;

   typedef enum logic [2:0] {
      FR_ST_OPC,
      FR_ST_ADDR,
      FR_ST_DUMMY,
      FR_ST_WDATA,
      FR_ST_RDATA,
      FR_ST_SRW,
      FR_ST_IGNORE,
      FR_ST_DONE
   } fr_state_t;

   typedef struct packed {
      fr_cmd_t cmd;
      logic mode3;
   } fr_evt_t;

endpackage : fr_pkg

/* fr_sync.sv */
module fr_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [W-1:0] meta_r;

   // First stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule : fr_sync

/* fr_front.sv */
// Summary of operation
// [RULE_01] Three address bytes, low 18 bits used
// [RULE_02] Memory byte written as it completes
// [RULE_03] Clock level at select picks mode
// [RULE_04] Sample on rise, drive on fall
// [RULE_05] Mode 3 first rise follows first toggle
// [RULE_06] Master idles clock per chosen mode
// [RULE_07] First byte opcode, then address, data
// [RULE_08] One command per select period
// [RULE_09] Deselected: input ignored, output floats
// [RULE_10] All bytes shifted MSB first
// [RULE_11] Master should send ignored bits zero; fr_master sends toggling bits for bytes past its tx list
// [RULE_12] Bad opcode: ignore until next select
// [RULE_13] Eight-bit status register configures device
// [RULE_14] Decode set write latch opcode
// [RULE_15] Decode clear write latch opcode
// [RULE_16] Decode status read and write opcodes
// [RULE_17] Decode read, fast read, write opcodes
// [RULE_18] Decode sleep and identification opcodes
// [RULE_19] Master waits power-up delay first
// [RULE_20] Hold low freezes clock and select; fr_front freezes only the clock, a select rise during hold ends the frame
// [RULE_21] Output driven only for read data
// [RULE_22] Decode on eighth rise, data next fall
`include "fr_regs.svh"

module fr_front #(
   parameter int ADDR_W = `FR_ADDR_W,
   parameter int ID_LEN = `FR_ID_LEN,
   // Arbitrary identification value
   parameter logic [8*ID_LEN-1:0] ID_VAL = {ID_LEN{8'h5A}}
) (
   // Core clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Serial link
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   input wire logic spi_hold_n,
   input wire logic spi_wp_n,
   // Serial output pin
   output logic spi_so,
   output logic spi_so_oe_n,
   // Core-side report
   output logic cmd_seen,
   output fr_pkg::fr_cmd_t cmd_code,
   output logic mode3_seen,
   output logic frame_act,
   output logic sleep_req
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [7:0] mem_r [0:(1<<ADDR_W)-1];

   fr_pkg::fr_state_t state_r;
   fr_pkg::fr_cmd_t cmd_r;
   logic [2:0] bit_cnt_r;
   logic [6:0] rx_sh_r;
   logic [1:0] addr_n_r;
   logic [ADDR_W-1:0] addr_r;
   logic [3:0] id_idx_r;
   logic rd_act_r;
   logic ld_r;
   logic [7:0] ld_byte_r;
   logic first_r;
   logic mode3_r;
   logic wel_r;
   logic wpen_r;
   logic [1:0] bp_r;
   logic set_pend_r;
   logic clr_pend_r;
   logic evt_tgl_r;
   fr_pkg::fr_evt_t evt_word_r;
   logic [6:0] tx_sh_r;
   logic [1:0] sync_q;
   logic tgl_d_r;

   logic [7:0] rx_byte;
   logic byte_done;
   logic [ADDR_W-1:0] addr_in;
   logic [7:0] status_byte;
   logic mem_we;
   logic sr_we;
   logic so_off;
   logic evt_new;
   fr_pkg::fr_cmd_t op_cmd;

   function automatic fr_pkg::fr_cmd_t fr_decode(input logic [7:0] op);
      fr_pkg::fr_cmd_t c;
      c = fr_pkg::FR_CMD_BAD;
      unique case (op)
         `FR_OP_SET_WEL: c = fr_pkg::FR_CMD_SET_WEL; // [RULE_14]
         `FR_OP_CLR_WEL: c = fr_pkg::FR_CMD_CLR_WEL; // [RULE_15]
         `FR_OP_SR_RD: c = fr_pkg::FR_CMD_SR_RD; // [RULE_16]
         `FR_OP_SR_WR: c = fr_pkg::FR_CMD_SR_WR; // [RULE_16]
         `FR_OP_RD: c = fr_pkg::FR_CMD_RD; // [RULE_17]
         `FR_OP_FRD: c = fr_pkg::FR_CMD_FRD; // [RULE_17]
         `FR_OP_WR: c = fr_pkg::FR_CMD_WR; // [RULE_17]
         `FR_OP_SLEEP: c = fr_pkg::FR_CMD_SLEEP; // [RULE_18]
         `FR_OP_ID: c = fr_pkg::FR_CMD_ID; // [RULE_18]
         default: c = fr_pkg::FR_CMD_BAD;
      endcase
      return c;
   endfunction : fr_decode

   function automatic logic fr_protected(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
      logic p;
      unique case (bp)
         `FR_BP_NONE: p = 1'b0;
         `FR_BP_QUARTER: p = (a[ADDR_W-1 -: 2] == `FR_TOP_QUARTER);
         `FR_BP_HALF: p = a[ADDR_W-1];
         default: p = 1'b1;
      endcase
      return p;
   endfunction : fr_protected

   function automatic logic [7:0] fr_id_byte(input logic [3:0] idx);
      logic [7:0] b;
      b = ID_VAL[8*(ID_LEN-1-int'(idx)) +: 8];
      return b;
   endfunction : fr_id_byte

   // MSB arrives first, so the new bit lands at the bottom
   assign rx_byte = {rx_sh_r, spi_si}; // [RULE_10]
   assign byte_done = (bit_cnt_r == `FR_BIT_LAST);
   assign addr_in = {addr_r[ADDR_W-9:0], rx_byte}; // [RULE_01]
   assign op_cmd = fr_decode(rx_byte);

   always_comb begin
      status_byte = `FR_SR_FIXED; // [RULE_13]
      status_byte[`FR_SR_WPEN] = wpen_r;
      status_byte[`FR_SR_BP1] = bp_r[1];
      status_byte[`FR_SR_BP0] = bp_r[0];
      status_byte[`FR_SR_WEL] = wel_r;
   end

   assign mem_we = spi_hold_n && byte_done && (state_r == fr_pkg::FR_ST_WDATA)
                   && wel_r && !fr_protected(bp_r, addr_r);
   assign sr_we = spi_hold_n && byte_done && (state_r == fr_pkg::FR_ST_SRW)
                  && wel_r && !(wpen_r && !spi_wp_n);

   // Mode caught on the select edge itself
   always_ff @(negedge spi_cs_n or negedge rst_n) begin
      if (!rst_n) begin
         mode3_r <= 1'b0;
      end else begin
         mode3_r <= spi_sck; // [RULE_03]
      end
   end

   // Frame logic; select high clears it, so each frame starts fresh
   always_ff @(posedge spi_sck or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         state_r <= fr_pkg::FR_ST_OPC; // [RULE_08] [RULE_09]
         cmd_r <= fr_pkg::FR_CMD_NONE;
         bit_cnt_r <= `FR_BIT_FIRST;
         rx_sh_r <= '0;
         addr_n_r <= '0;
         addr_r <= '0;
         id_idx_r <= '0;
         rd_act_r <= 1'b0;
         ld_r <= 1'b0;
         ld_byte_r <= '0;
         first_r <= 1'b1;
      end else if (spi_hold_n) begin // [RULE_20]
         // Mode 3 needs no special case: no rise occurs before the first fall
         first_r <= 1'b0; // [RULE_04] [RULE_05]
         bit_cnt_r <= bit_cnt_r + 3'h1;
         rx_sh_r <= rx_byte[6:0];
         ld_r <= 1'b0;
         if (byte_done) begin
            unique case (state_r)
               fr_pkg::FR_ST_OPC: begin
                  cmd_r <= op_cmd; // [RULE_07] [RULE_22]
                  unique case (op_cmd)
                     fr_pkg::FR_CMD_SR_RD: begin
                        state_r <= fr_pkg::FR_ST_RDATA;
                        rd_act_r <= 1'b1;
                        ld_r <= 1'b1;
                        ld_byte_r <= status_byte;
                     end
                     fr_pkg::FR_CMD_SR_WR: begin
                        state_r <= fr_pkg::FR_ST_SRW;
                     end
                     fr_pkg::FR_CMD_RD, fr_pkg::FR_CMD_FRD, fr_pkg::FR_CMD_WR: begin
                        state_r <= fr_pkg::FR_ST_ADDR;
                     end
                     fr_pkg::FR_CMD_ID: begin
                        state_r <= fr_pkg::FR_ST_RDATA;
                        rd_act_r <= 1'b1;
                        ld_r <= 1'b1;
                        ld_byte_r <= fr_id_byte(4'h0);
                        id_idx_r <= 4'h1;
                     end
                     fr_pkg::FR_CMD_BAD: begin
                        state_r <= fr_pkg::FR_ST_IGNORE; // [RULE_12]
                     end
                     default: begin
                        state_r <= fr_pkg::FR_ST_DONE;
                     end
                  endcase
               end
               fr_pkg::FR_ST_ADDR: begin
                  addr_r <= addr_in; // [RULE_01]
                  addr_n_r <= addr_n_r + 2'h1;
                  if (addr_n_r == `FR_ADDR_LAST) begin
                     unique case (cmd_r)
                        fr_pkg::FR_CMD_RD: begin
                           state_r <= fr_pkg::FR_ST_RDATA;
                           rd_act_r <= 1'b1;
                           ld_r <= 1'b1; // [RULE_22]
                           ld_byte_r <= mem_r[addr_in];
                           addr_r <= addr_in + ADDR_W'(1);
                        end
                        fr_pkg::FR_CMD_FRD: begin
                           state_r <= fr_pkg::FR_ST_DUMMY;
                        end
                        default: begin
                           state_r <= fr_pkg::FR_ST_WDATA;
                        end
                     endcase
                  end
               end
               fr_pkg::FR_ST_DUMMY: begin
                  state_r <= fr_pkg::FR_ST_RDATA;
                  rd_act_r <= 1'b1;
                  ld_r <= 1'b1;
                  ld_byte_r <= mem_r[addr_r];
                  addr_r <= addr_r + ADDR_W'(1);
               end
               fr_pkg::FR_ST_WDATA: begin
                  // Address wraps through the whole array
                  addr_r <= addr_r + ADDR_W'(1); // [RULE_02]
               end
               fr_pkg::FR_ST_RDATA: begin
                  ld_r <= 1'b1;
                  unique case (cmd_r)
                     fr_pkg::FR_CMD_SR_RD: begin
                        ld_byte_r <= status_byte;
                     end
                     fr_pkg::FR_CMD_ID: begin
                        ld_byte_r <= fr_id_byte(id_idx_r);
                        if (id_idx_r == 4'(ID_LEN - 1)) begin
                           id_idx_r <= '0;
                        end else begin
                           id_idx_r <= id_idx_r + 4'h1;
                        end
                     end
                     default: begin
                        ld_byte_r <= mem_r[addr_r];
                        addr_r <= addr_r + ADDR_W'(1);
                     end
                  endcase
               end
               fr_pkg::FR_ST_SRW: begin
                  state_r <= fr_pkg::FR_ST_DONE; // [RULE_08]
               end
               default: begin
                  state_r <= state_r; // [RULE_12]
               end
            endcase
         end
      end
   end

   // Byte lands with its last bit, so no busy polling is ever needed
   always_ff @(posedge spi_sck) begin
      if (mem_we && !spi_cs_n) begin
         mem_r[addr_r] <= rx_byte; // [RULE_02]
      end
   end

   // Status bits survive deselect
   always_ff @(posedge spi_sck or negedge rst_n) begin
      if (!rst_n) begin
         wpen_r <= `FR_SR_WPEN_RST;
         bp_r <= `FR_SR_BP_RST;
      end else if (sr_we && !spi_cs_n) begin
         wpen_r <= rx_byte[`FR_SR_WPEN]; // [RULE_13]
         bp_r <= {rx_byte[`FR_SR_BP1], rx_byte[`FR_SR_BP0]};
      end
   end

   // Latch change requests, applied when select rises
   always_ff @(posedge spi_sck or negedge rst_n) begin
      if (!rst_n) begin
         set_pend_r <= 1'b0;
         clr_pend_r <= 1'b0;
      end else if (!spi_cs_n && spi_hold_n) begin
         if (byte_done && state_r == fr_pkg::FR_ST_OPC) begin
            set_pend_r <= (op_cmd == fr_pkg::FR_CMD_SET_WEL); // [RULE_14]
            clr_pend_r <= (op_cmd == fr_pkg::FR_CMD_CLR_WEL) // [RULE_15]
                          || (op_cmd == fr_pkg::FR_CMD_SR_WR)
                          || (op_cmd == fr_pkg::FR_CMD_WR);
         end else if (first_r) begin
            set_pend_r <= 1'b0;
            clr_pend_r <= 1'b0;
         end
      end
   end

   // Stable through the frame, so reads inside it see one value
   always_ff @(posedge spi_cs_n or negedge rst_n) begin
      if (!rst_n) begin
         wel_r <= 1'b0;
      end else if (set_pend_r) begin
         wel_r <= 1'b1;
      end else if (clr_pend_r) begin
         wel_r <= 1'b0;
      end
   end

   // Output data changes on falling edges and clears when select rises
   always_ff @(negedge spi_sck or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         spi_so <= 1'b0;
         tx_sh_r <= '0;
      end else if (spi_hold_n) begin // [RULE_20]
         if (ld_r) begin
            spi_so <= ld_byte_r[7]; // [RULE_04] [RULE_10] [RULE_22]
            tx_sh_r <= ld_byte_r[6:0];
         end else begin
            spi_so <= tx_sh_r[6];
            tx_sh_r <= {tx_sh_r[5:0], 1'b0};
         end
      end
   end

   // Hold or deselect floats the pin at once, without a clock
   assign so_off = spi_cs_n | ~spi_hold_n;

   always_ff @(negedge spi_sck or posedge so_off) begin
      if (so_off) begin
         spi_so_oe_n <= 1'b1; // [RULE_09] [RULE_21]
      end else begin
         spi_so_oe_n <= ~rd_act_r; // [RULE_21] [RULE_12]
      end
   end

   // Opcode event toward the core, word held until the next opcode
   always_ff @(posedge spi_sck or negedge rst_n) begin
      if (!rst_n) begin
         evt_tgl_r <= 1'b0;
         evt_word_r <= '{cmd: fr_pkg::FR_CMD_NONE, mode3: 1'b0};
      end else if (!spi_cs_n && spi_hold_n && byte_done && state_r == fr_pkg::FR_ST_OPC) begin
         evt_tgl_r <= ~evt_tgl_r;
         evt_word_r <= '{cmd: op_cmd, mode3: mode3_r};
      end
   end

   fr_sync #(
      .W(2)
   ) u_sync (
      .clk(core_clk),
      .rst_n(rst_n),
      // Select inverted so the reset level matches idle: no false frame after reset
      .d({evt_tgl_r, ~spi_cs_n}),
      .q(sync_q)
   );

   assign evt_new = (sync_q[1] != tgl_d_r);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tgl_d_r <= 1'b0;
         cmd_seen <= 1'b0;
         cmd_code <= fr_pkg::FR_CMD_NONE;
         mode3_seen <= 1'b0;
      end else begin
         tgl_d_r <= sync_q[1];
         cmd_seen <= evt_new;
         if (evt_new) begin
            cmd_code <= evt_word_r.cmd;
            mode3_seen <= evt_word_r.mode3;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_act <= 1'b0;
      end else begin
         frame_act <= sync_q[0];
      end
   end

   // Sleep request set wins over the wake on a new selection
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_req <= 1'b0;
      end else if (evt_new && evt_word_r.cmd == fr_pkg::FR_CMD_SLEEP) begin
         sleep_req <= 1'b1; // [RULE_18]
      end else if (sync_q[0] && !frame_act) begin
         sleep_req <= 1'b0;
      end
   end

endmodule : fr_front

/* fr_front_checker.sv */
module fr_front_checker (
   // Core clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Serial link
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   input wire logic spi_hold_n,
   input wire logic spi_wp_n,
   input wire logic spi_so,
   input wire logic spi_so_oe_n,
   // Core-side report
   input wire logic cmd_seen,
   input wire fr_pkg::fr_cmd_t cmd_code,
   input wire logic mode3_seen,
   input wire logic frame_act,
   input wire logic sleep_req
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   AST_DESEL_FLOAT: assert property (spi_cs_n |-> spi_so_oe_n)
      else $error("output driven while deselected");
   AST_HOLD_FLOAT: assert property (!spi_hold_n |-> spi_so_oe_n)
      else $error("output driven during hold");
   AST_SO_ON_FALL: assert property ($changed(spi_so) && !spi_cs_n && spi_hold_n |-> !spi_sck)
      else $error("output changed off falling clock");
   AST_OE_ON_FALL: assert property ($fell(spi_so_oe_n) |-> !spi_sck && !spi_cs_n)
      else $error("output enabled off falling clock");
   AST_CMD_PULSE: assert property (cmd_seen |=> !cmd_seen)
      else $error("decode pulse too long");
   AST_CMD_CODE: assert property (cmd_seen |-> cmd_code != fr_pkg::FR_CMD_NONE && frame_act)
      else $error("decode outside frame or empty");
   AST_CODE_HELD: assert property (!cmd_seen |-> $stable(cmd_code))
      else $error("command code moved without decode");
   AST_FRAME_ON: assert property ($fell(spi_cs_n) |-> ##[1:5] frame_act)
      else $error("frame start not seen");
   AST_FRAME_OFF: assert property ($rose(spi_cs_n) |-> ##[1:5] !frame_act)
      else $error("frame end not seen");
   AST_SLEEP_KEEP: assert property (sleep_req && spi_cs_n && !frame_act |=> sleep_req)
      else $error("sleep request lost while idle");
endmodule : fr_front_checker

bind fr_front fr_front_checker chk (.core_clk(core_clk), .rst_n(rst_n), .spi_sck(spi_sck),
   .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_hold_n(spi_hold_n), .spi_wp_n(spi_wp_n), .spi_so(spi_so),
   .spi_so_oe_n(spi_so_oe_n), .cmd_seen(cmd_seen), .cmd_code(cmd_code), .mode3_seen(mode3_seen),
   .frame_act(frame_act), .sleep_req(sleep_req));

/* fr_master.sv */
module fr_master (
   // Driven link
   output logic spi_sck,
   output logic spi_cs_n,
   output logic spi_si,
   output logic spi_hold_n,
   output logic spi_wp_n,
   // Returned data
   input wire logic spi_so,
   input wire logic spi_so_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] rx [0:15];
   logic oe_low;
   int hold_at;
   logic hold_oe;

   initial begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b0;
      spi_si = 1'b0;
      spi_hold_n = 1'b1;
      spi_wp_n = 1'b1;
      oe_low = 1'b0;
      hold_at = -1;
      hold_oe = 1'b0;
      #3;
      // A real rising select clears the frame logic, which has no other reset
      spi_cs_n = 1'b1;
   end

   // Odd offset keeps the link out of phase with the core clock
   task automatic frame(input logic [7:0] tx[$], input int n, input logic m3);
      int i;
      int b;
      oe_low = 1'b0;
      spi_sck = m3; // Idle level per mode
      #40.3;
      spi_cs_n = 1'b0; // One command per select
      #80;
      for (i = 0; i < n; i++) begin
         for (b = 7; b >= 0; b--) begin
            spi_sck = 1'b0;
            spi_si = (i < tx.size()) ? tx[i][b] : ~spi_si; // MSB first
            #80;
            if (i * 8 + 7 - b == hold_at) begin
               // Pause with the clock low; the stray clock pulse must be ignored
               spi_hold_n = 1'b0;
               #20;
               hold_oe = spi_so_oe_n;
               spi_sck = 1'b1;
               #20;
               spi_sck = 1'b0;
               #20;
               spi_hold_n = 1'b1;
               #20;
            end
            spi_sck = 1'b1;
            rx[i][b] = spi_so; // Taken on rise
            if (spi_so_oe_n === 1'b0) begin
               oe_low = 1'b1;
            end
            #80;
         end
      end
      if (!m3) begin
         spi_sck = 1'b0;
      end
      #40;
      spi_cs_n = 1'b1;
      spi_si = ~spi_si;
   endtask : frame
endmodule : fr_master

/* test_fr_front.sv */
module test_fr_front;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk;
   logic rst_n;
   logic spi_sck;
   logic spi_cs_n;
   logic spi_si;
   logic spi_hold_n;
   logic spi_wp_n;
   logic spi_so;
   logic spi_so_oe_n;
   logic cmd_seen;
   fr_pkg::fr_cmd_t cmd_code;
   logic mode3_seen;
   logic frame_act;
   logic sleep_req;
   int n_mismatch;
   int check_count;
   int i;

   fr_front dut (.core_clk(core_clk), .rst_n(rst_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
      .spi_si(spi_si), .spi_hold_n(spi_hold_n), .spi_wp_n(spi_wp_n), .spi_so(spi_so),
      .spi_so_oe_n(spi_so_oe_n), .cmd_seen(cmd_seen), .cmd_code(cmd_code), .mode3_seen(mode3_seen),
      .frame_act(frame_act), .sleep_req(sleep_req));
   fr_master mst (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_hold_n(spi_hold_n),
      .spi_wp_n(spi_wp_n), .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n));

   always #2 core_clk = ~core_clk;

   task automatic end_of_test;
      if (n_mismatch == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
      end
   endtask : chk_byte

   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chk_bit

   task automatic chk_cmd(input fr_pkg::fr_cmd_t got, input fr_pkg::fr_cmd_t exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t command %0d expected %0d", $time, got, exp);
      end
   endtask : chk_cmd

   task automatic go(input logic [7:0] tx[$], input int n, input logic m3);
      mst.frame(tx, n, m3);
      repeat (10) @(negedge core_clk);
   endtask : go

   task automatic t_status_reset;
      go('{8'h05}, 2, 1'b0);
      chk_byte(mst.rx[1], 8'h40);
      chk_cmd(cmd_code, fr_pkg::FR_CMD_SR_RD);
      chk_bit(mode3_seen, 1'b0);
      chk_bit(mst.oe_low, 1'b1);
   endtask : t_status_reset

   task automatic t_latch;
      go('{8'h06}, 1, 1'b1);
      chk_cmd(cmd_code, fr_pkg::FR_CMD_SET_WEL);
      chk_bit(mode3_seen, 1'b1);
      go('{8'h05}, 2, 1'b1);
      chk_byte(mst.rx[1], 8'h42);
      go('{8'h04}, 1, 1'b0);
      chk_cmd(cmd_code, fr_pkg::FR_CMD_CLR_WEL);
      go('{8'h05}, 2, 1'b0);
      chk_byte(mst.rx[1], 8'h40);
   endtask : t_latch

   task automatic t_memory;
      go('{8'h06}, 1, 1'b0);
      go('{8'h02, 8'hFC, 8'h01, 8'h23, 8'hAB, 8'hCD}, 6, 1'b0);
      chk_cmd(cmd_code, fr_pkg::FR_CMD_WR);
      go('{8'h03, 8'h00, 8'h01, 8'h23}, 6, 1'b0);
      chk_byte(mst.rx[4], 8'hAB);
      chk_byte(mst.rx[5], 8'hCD);
      go('{8'h0B, 8'h00, 8'h01, 8'h24, 8'h00}, 6, 1'b1);
      chk_byte(mst.rx[5], 8'hCD);
      go('{8'h05}, 2, 1'b0);
      chk_byte(mst.rx[1], 8'h40);
   endtask : t_memory

   task automatic t_status_write;
      go('{8'h06}, 1, 1'b0);
      go('{8'h01, 8'h0C}, 2, 1'b0);
      chk_cmd(cmd_code, fr_pkg::FR_CMD_SR_WR);
      go('{8'h05}, 2, 1'b1);
      chk_byte(mst.rx[1], 8'h4C);
      go('{8'h06}, 1, 1'b0);
      go('{8'h01, 8'h00}, 2, 1'b0);
   endtask : t_status_write

   task automatic t_bad_opcode;
      go('{8'hFF, 8'h05}, 3, 1'b0);
      chk_cmd(cmd_code, fr_pkg::FR_CMD_BAD);
      chk_bit(mst.oe_low, 1'b0);
      chk_bit(spi_so_oe_n, 1'b1);
   endtask : t_bad_opcode

   task automatic t_hold;
      mst.spi_hold_n = 1'b0;
      repeat (8) @(negedge core_clk);
      chk_bit(spi_so_oe_n, 1'b1);
      mst.spi_hold_n = 1'b1;
      repeat (8) @(negedge core_clk);
      go('{8'h06}, 1, 1'b0);
      mst.hold_at = 10;
      go('{8'h05}, 2, 1'b0);
      mst.hold_at = -1;
      chk_bit(mst.hold_oe, 1'b1);
      chk_byte(mst.rx[1], 8'h42);
   endtask : t_hold

   task automatic t_sleep_id;
      go('{8'hB9}, 1, 1'b0);
      chk_cmd(cmd_code, fr_pkg::FR_CMD_SLEEP);
      chk_bit(sleep_req, 1'b1);
      go('{8'h9F}, 11, 1'b1);
      chk_cmd(cmd_code, fr_pkg::FR_CMD_ID);
      chk_bit(sleep_req, 1'b0);
      for (i = 1; i < 11; i++) begin
         chk_byte(mst.rx[i], 8'h5A);
      end
   endtask : t_sleep_id

   initial begin
      core_clk = 1'b0;
      rst_n = 1'b1;
      n_mismatch = 0;
      check_count = 0;
      #1;
      // A real falling edge, so every asynchronous reset branch runs
      rst_n = 1'b0;
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
      @(negedge core_clk);
      chk_bit(frame_act, 1'b0);
      repeat (19) @(negedge core_clk); // Power-up wait
      t_status_reset();
      t_latch();
      t_memory();
      t_status_write();
      t_bad_opcode();
      t_hold();
      t_sleep_id();
      end_of_test();
   end

   // Run needs about 75 us of link traffic
   initial begin
      #300000;
      n_mismatch++;
      end_of_test();
   end
endmodule : test_fr_front
